/* rtl/epba_defines.svh */
`ifndef EPBA_DEFINES_SVH
`define EPBA_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define EPBA_CTRL_OFFSET    12'h000
`define EPBA_STATUS_OFFSET  12'h004
`define EPBA_CTRL_RESET     5'h00

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define EPBA_CTRL_DELAY_BIT   0
`define EPBA_CTRL_IGNORE_BIT  1
`define EPBA_CTRL_TAG_BIT     2
`define EPBA_CTRL_MONITOR_BIT 3
`define EPBA_CTRL_LOCK_BIT    4

// ----------------------------------------------------------------------------
// synchroniser lane positions and idle value
// ----------------------------------------------------------------------------
`define EPBA_SY_TREQ   0
`define EPBA_SY_TGACK  1
`define EPBA_SY_HHALT  2
`define EPBA_SY_START  3
`define EPBA_SY_DRST   4
`define EPBA_SY_AS     5
`define EPBA_SY_HALT   6
`define EPBA_SY_RESET  7
`define EPBA_SYNC_IDLE 8'hff

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define EPBA_TS_DELAY_CLKS 4

`endif

/* rtl/epba_pkg.sv */
`default_nettype none

package epba_pkg;

  // arbiter states
  typedef enum logic [2:0] {
    EPBA_ARB_IDLE    = 3'b000,
    EPBA_ARB_REQ     = 3'b001,
    EPBA_ARB_GRANT   = 3'b010,
    EPBA_ARB_TARGET  = 3'b011,
    EPBA_ARB_HOST    = 3'b100
  } epba_arb_t;

  // handshake tagging states
  typedef enum logic [1:0] {
    EPBA_TAG_IDLE    = 2'b00,
    EPBA_TAG_QUAL    = 2'b01,
    EPBA_TAG_PULSE   = 2'b10,
    EPBA_TAG_INHIBIT = 2'b11
  } epba_tag_t;

endpackage

`default_nettype wire

/* rtl/epba_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "epba_defines.svh"

// Operation
// - latch target and host requests; request cpu bus while either pends
// - target request, grant ack, host halt, start, dma reset are synchronised
// - the arbiter state advances only on the processor clock
// - processor address strobe is synchronised before arbitration uses it
// - onward grant combines processor grant with arbiter grant
// - a dedicated flip-flop gives an early dma-active indication
// - generate timed dma strobes while the host owns the bus
// - first clock after grant ack: qualifier on, tag generator released
// - tag generator emits exactly one analysis clock pulse
// - third clock: qualifier off, tag generator cleared again
// - after a tag, wait for grant ack negated one clock
// - suppress memory-available when ignoring dma or tagging
// - qualifier asserted whenever monitoring-only mode is selected
// - tristate condition: halt or reset, no dma, no memory cycle
// - undelayed drive enable combines condition with arbiter tristate
// - delay option routes condition through a four-clock shift register
// - drive target bus grant low to hand the bus over
// - with lock set, pulse transfer ack low per emulation memory access
module epba_arbiter (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic        target_bus_request_n_i,
  input  wire logic        target_grant_ack_n_i,
  input  wire logic        host_halt_request_n_i,
  input  wire logic        run_start_n_i,
  input  wire logic        dma_reset_n_i,
  input  wire logic        cpu_as_n_i,
  input  wire logic        cpu_halt_n_i,
  input  wire logic        cpu_reset_n_i,
  input  wire logic        cpu_bus_grant_n_i,
  input  wire logic        emu_mem_access_i,
  output logic             cpu_bus_request_n_o,
  output logic             cpu_grant_ack_n_o,
  output logic             target_bus_grant_n_o,
  output logic             dma_cycle_n_o,
  output logic             memory_cycle_n_o,
  output logic             dma_active_async_o,
  output logic             host_dma_strobe_n_o,
  output logic             analysis_only_qualifier_n_o,
  output logic             tag_pulse_o,
  output logic             memavail_suppress_o,
  output logic             memory_available_flag_o,
  output logic             target_drive_enable_n_o,
  output logic             target_transfer_ack_n_o,
  output logic             target_transfer_ack_oe_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         sync1;
    logic [7:0]         sync2;
    epba_pkg::epba_arb_t arb;
    epba_pkg::epba_tag_t tag;
    logic               tgt_pend;
    logic               host_pend;
    logic               dma_active;
    logic               tag_pulse;
    logic               strobe;
    logic               ack;
    logic               ack_done;
    logic [3:0]         ts_shift;
    logic [4:0]         ctrl;
    logic               wr_pend;
    logic [11:0]        wr_addr;
    logic [31:0]        rdata;
  } epba_state_t;

  epba_state_t state_ff;
  epba_state_t nxt_state;

  // synchronised and derived views, all active high
  logic s_treq;
  logic s_tgack;
  logic s_hreq;
  logic s_start;
  logic s_drst;
  logic s_as;
  logic s_halt;
  logic s_reset;
  logic arb_grant;
  logic cpu_grant;
  logic ts_cond;
  logic ts_arb;
  logic addr_ok;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // word-aligned offset match inside the 4 KiB window
  function automatic logic epba_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // --------------------------------------------------------------------------
  // combinational views
  // --------------------------------------------------------------------------
  // synchroniser second stages only; first stage feeds nothing else
  assign s_treq  = ~state_ff.sync2[`EPBA_SY_TREQ];
  assign s_tgack = ~state_ff.sync2[`EPBA_SY_TGACK];
  assign s_hreq  = ~state_ff.sync2[`EPBA_SY_HHALT];
  assign s_start = ~state_ff.sync2[`EPBA_SY_START];
  assign s_drst  = ~state_ff.sync2[`EPBA_SY_DRST];
  assign s_as    = ~state_ff.sync2[`EPBA_SY_AS];
  assign s_halt  = ~state_ff.sync2[`EPBA_SY_HALT];
  assign s_reset = ~state_ff.sync2[`EPBA_SY_RESET];

  // arbiter grant and processor grant gated together
  assign arb_grant = state_ff.arb == epba_pkg::EPBA_ARB_GRANT ||
                     state_ff.arb == epba_pkg::EPBA_ARB_TARGET;
  assign cpu_grant = ~cpu_bus_grant_n_i;
  assign ts_arb    = state_ff.arb == epba_pkg::EPBA_ARB_TARGET ||
                     state_ff.arb == epba_pkg::EPBA_ARB_HOST;
  assign ts_cond   = (s_halt | s_reset) & ~ts_arb & ~s_as;
  assign addr_ok   = hsel_i & hready_i & htrans_i[1];

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    // two-flop synchronisers for every pin-side input except processor grant and emulation memory access
    nxt_state.sync1 = {cpu_reset_n_i, cpu_halt_n_i, cpu_as_n_i, dma_reset_n_i,
                       run_start_n_i, host_halt_request_n_i, target_grant_ack_n_i,
                       target_bus_request_n_i};
    nxt_state.sync2 = state_ff.sync1;

    // request latches; a new request wins over the start clear, but dma reset clears both
    if (s_start) begin
      nxt_state.host_pend = 1'b0;
    end
    if (s_treq) begin
      nxt_state.tgt_pend = 1'b1;
    end
    if (s_hreq) begin
      nxt_state.host_pend = 1'b1;
    end

    // arbiter, clocked by the processor clock only
    case (state_ff.arb)
      epba_pkg::EPBA_ARB_IDLE: begin
        if (state_ff.tgt_pend || state_ff.host_pend) begin
          nxt_state.arb = epba_pkg::EPBA_ARB_REQ;
        end
      end
      epba_pkg::EPBA_ARB_REQ: begin
        if (cpu_grant && state_ff.host_pend) begin
          nxt_state.arb = epba_pkg::EPBA_ARB_HOST;
        end else if (cpu_grant) begin
          nxt_state.arb = epba_pkg::EPBA_ARB_GRANT;
        end
      end
      epba_pkg::EPBA_ARB_GRANT: begin
        if (s_tgack) begin
          nxt_state.arb      = epba_pkg::EPBA_ARB_TARGET;
          nxt_state.tgt_pend = s_treq;
        end
      end
      epba_pkg::EPBA_ARB_TARGET: begin
        if (!s_tgack) begin
          nxt_state.arb = epba_pkg::EPBA_ARB_IDLE;
        end
      end
      epba_pkg::EPBA_ARB_HOST: begin
        if (!s_hreq) begin
          nxt_state.arb       = epba_pkg::EPBA_ARB_IDLE;
          nxt_state.host_pend = 1'b0;
        end
      end
      default: begin
        nxt_state.arb = epba_pkg::EPBA_ARB_IDLE;
      end
    endcase

    // timed strobe while the host works in emulation memory
    nxt_state.strobe = nxt_state.arb == epba_pkg::EPBA_ARB_HOST && !s_as;

    // early dma indication, set from the raw processor grant
    nxt_state.dma_active = (cpu_grant && state_ff.arb != epba_pkg::EPBA_ARB_IDLE) ||
                           state_ff.arb == epba_pkg::EPBA_ARB_TARGET;

    // handshake tagging
    nxt_state.tag_pulse = 1'b0;
    case (state_ff.tag)
      epba_pkg::EPBA_TAG_IDLE: begin
        if (s_tgack && state_ff.ctrl[`EPBA_CTRL_TAG_BIT]) begin
          nxt_state.tag = epba_pkg::EPBA_TAG_QUAL;
        end
      end
      epba_pkg::EPBA_TAG_QUAL: begin
        nxt_state.tag       = epba_pkg::EPBA_TAG_PULSE;
        nxt_state.tag_pulse = 1'b1;
      end
      epba_pkg::EPBA_TAG_PULSE: begin
        nxt_state.tag = epba_pkg::EPBA_TAG_INHIBIT;
      end
      epba_pkg::EPBA_TAG_INHIBIT: begin
        if (!s_tgack) begin
          nxt_state.tag = epba_pkg::EPBA_TAG_IDLE;
        end
      end
      default: begin
        nxt_state.tag = epba_pkg::EPBA_TAG_IDLE;
      end
    endcase

    // transfer acknowledge, one pulse per emulation memory access
    nxt_state.ack = 1'b0;
    if (!s_as) begin
      nxt_state.ack_done = 1'b0;
    end else if (state_ff.ctrl[`EPBA_CTRL_LOCK_BIT] && emu_mem_access_i &&
                 state_ff.arb == epba_pkg::EPBA_ARB_TARGET && !state_ff.ack_done) begin
      nxt_state.ack      = 1'b1;
      nxt_state.ack_done = 1'b1;
    end

    // tristate delay line
    nxt_state.ts_shift = {state_ff.ts_shift[2:0], ts_cond};

    // dma reset forces the arbiter idle
    if (s_drst) begin
      nxt_state.arb       = epba_pkg::EPBA_ARB_IDLE;
      nxt_state.tgt_pend  = 1'b0;
      nxt_state.host_pend = 1'b0;
      nxt_state.strobe    = 1'b0;
    end

    // bus slave: data phase write, address phase capture
    if (state_ff.wr_pend && epba_hit(state_ff.wr_addr, `EPBA_CTRL_OFFSET)) begin
      nxt_state.ctrl = hwdata_i[4:0];
    end
    nxt_state.wr_pend = addr_ok & hwrite_i;
    nxt_state.wr_addr = haddr_i[11:0];
    if (addr_ok && !hwrite_i) begin
      if (epba_hit(haddr_i[11:0], `EPBA_CTRL_OFFSET)) begin
        nxt_state.rdata = {27'h0000000, state_ff.ctrl};
      end else if (epba_hit(haddr_i[11:0], `EPBA_STATUS_OFFSET)) begin
        nxt_state.rdata = {20'h00000, state_ff.ts_shift, state_ff.tag,
                           state_ff.dma_active, state_ff.host_pend,
                           state_ff.tgt_pend, state_ff.arb};
      end else begin
        nxt_state.rdata = 32'h00000000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff            <= '0;
      state_ff.sync1      <= `EPBA_SYNC_IDLE;
      state_ff.sync2      <= `EPBA_SYNC_IDLE;
      state_ff.arb        <= epba_pkg::EPBA_ARB_IDLE;
      state_ff.tag        <= epba_pkg::EPBA_TAG_IDLE;
      state_ff.ctrl       <= `EPBA_CTRL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // bus answers at once, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = state_ff.rdata;

  // arbitration handshakes
  assign cpu_bus_request_n_o  = ~(state_ff.arb == epba_pkg::EPBA_ARB_REQ ||
                                  state_ff.arb == epba_pkg::EPBA_ARB_GRANT ||
                                  state_ff.arb == epba_pkg::EPBA_ARB_TARGET ||
                                  state_ff.arb == epba_pkg::EPBA_ARB_HOST);
  assign target_bus_grant_n_o = ~(cpu_grant & arb_grant);
  assign cpu_grant_ack_n_o    = ~ts_arb;
  assign dma_cycle_n_o        = ~ts_arb;
  assign memory_cycle_n_o     = ~s_as;
  assign dma_active_async_o   = state_ff.dma_active;
  assign host_dma_strobe_n_o  = ~state_ff.strobe;

  // analysis qualifier and tag clock
  assign analysis_only_qualifier_n_o = ~(state_ff.tag == epba_pkg::EPBA_TAG_QUAL ||
                                         state_ff.tag == epba_pkg::EPBA_TAG_PULSE ||
                                         state_ff.ctrl[`EPBA_CTRL_MONITOR_BIT]);
  assign tag_pulse_o                 = state_ff.tag_pulse;

  // memory-available masking
  assign memavail_suppress_o     = state_ff.ctrl[`EPBA_CTRL_IGNORE_BIT] |
                                   state_ff.ctrl[`EPBA_CTRL_TAG_BIT];
  assign memory_available_flag_o = ~s_as & ~memavail_suppress_o;

  // target drive enable, direct or delayed
  assign target_drive_enable_n_o = state_ff.ctrl[`EPBA_CTRL_DELAY_BIT] ?
                                   (state_ff.ts_shift[3] | ts_arb) :
                                   (ts_cond | ts_arb);

  // open-drain style acknowledge to the target
  assign target_transfer_ack_n_o  = 1'b0;
  assign target_transfer_ack_oe_o = state_ff.ack;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_req_when_pend: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.arb == epba_pkg::EPBA_ARB_IDLE && state_ff.tgt_pend && !s_drst)
      |=> !cpu_bus_request_n_o)
    else $error("bus request missing while request pending");

  a_sync_depth: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff.sync2 == $past(state_ff.sync1))
    else $error("synchroniser stage skipped");

  a_grant_gated: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !target_bus_grant_n_o |-> (cpu_grant && arb_grant))
    else $error("target grant without both grants");

  a_dma_early: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($rose(state_ff.arb == epba_pkg::EPBA_ARB_TARGET)) |-> state_ff.dma_active)
    else $error("dma flag late");

  a_tag_qual: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.tag == epba_pkg::EPBA_TAG_IDLE && s_tgack &&
     state_ff.ctrl[`EPBA_CTRL_TAG_BIT]) |=> !analysis_only_qualifier_n_o)
    else $error("qualifier not asserted");

  a_tag_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(tag_pulse_o) |=> !tag_pulse_o ##1 !tag_pulse_o)
    else $error("tag pulse longer than one clock");

  a_tag_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.tag == epba_pkg::EPBA_TAG_QUAL) |=> ##1
      (state_ff.tag == epba_pkg::EPBA_TAG_INHIBIT))
    else $error("tag sequence did not close on third clock");

  a_tag_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.tag == epba_pkg::EPBA_TAG_INHIBIT && s_tgack) |=>
      state_ff.tag == epba_pkg::EPBA_TAG_INHIBIT)
    else $error("tag inhibit released early");

  a_suppress: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff.ctrl[`EPBA_CTRL_TAG_BIT] |-> !memory_available_flag_o && memavail_suppress_o)
    else $error("memory available not suppressed");

  a_ts_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.ctrl[`EPBA_CTRL_DELAY_BIT] && !ts_arb &&
     $past(ts_cond, 4) && $past(state_ff.ctrl[`EPBA_CTRL_DELAY_BIT], 4))
      |-> target_drive_enable_n_o)
    else $error("delayed tristate wrong");

  a_dma_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_drst |=> (state_ff.arb == epba_pkg::EPBA_ARB_IDLE && cpu_bus_request_n_o &&
                target_bus_grant_n_o))
    else $error("dma reset did not idle arbiter");

endmodule

`default_nettype wire

/* tb/epba_target_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// target dma master and processor grant echo
// ----------------------------------------------------------------------------
module epba_target_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] hold_i,
  input  wire logic       cpu_bus_request_n_i,
  input  wire logic       target_bus_grant_n_i,
  output logic            target_bus_request_n_o,
  output logic            target_grant_ack_n_o,
  output logic            cpu_bus_grant_n_o,
  output logic            done_o
);
  logic [3:0] cnt_ff;
  logic       busy_ff;

  assign done_o = ~busy_ff;

  // request, take the grant, hold acknowledge for hold_i plus one clocks
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      target_bus_request_n_o <= 1'b1;
      target_grant_ack_n_o   <= 1'b1;
      cpu_bus_grant_n_o      <= 1'b1;
      cnt_ff                 <= 4'h0;
      busy_ff                <= 1'b0;
    end else begin
      cpu_bus_grant_n_o <= cpu_bus_request_n_i; // processor grants a clock later
      if (go_i && !busy_ff) begin
        busy_ff                <= 1'b1;
        target_bus_request_n_o <= 1'b0;
      end else if (busy_ff && target_grant_ack_n_o && !target_bus_grant_n_i) begin
        target_bus_request_n_o <= 1'b1;
        target_grant_ack_n_o   <= 1'b0;
        cnt_ff                 <= hold_i;
      end else if (!target_grant_ack_n_o) begin
        if (cnt_ff == 4'h0) begin
          target_grant_ack_n_o <= 1'b1;
          busy_ff              <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_emulator_pod_bus_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_emulator_pod_bus_arbiter;
  logic        clk_i, sys_rst_i, hsel, hwrite, host_n, dma_rst_n, as_n, halt_n, emu_mem, go;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [3:0]  hold;
  logic        hready, hresp, req_n, gack_n, tgnt_n, dcyc_n, mcyc_n, hstb_n, qual_n, tag_p;
  logic        supp, avail, den_n, xack_oe, treq_n, tack_n, cgnt_n, mdone;
  logic        dact, xack_n, start_n, cpu_rst_n;
  int          errors = 0;
  int          check_count = 0;
  int          n, a, b, l0, l1;

  // ----------------------------------------------------------------------------
  // design and far-side model
  // ----------------------------------------------------------------------------
  epba_arbiter epba_arbiter_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .target_bus_request_n_i(treq_n), .target_grant_ack_n_i(tack_n),
    .host_halt_request_n_i(host_n), .run_start_n_i(start_n), .dma_reset_n_i(dma_rst_n),
    .cpu_as_n_i(as_n), .cpu_halt_n_i(halt_n), .cpu_reset_n_i(cpu_rst_n),
    .cpu_bus_grant_n_i(cgnt_n), .emu_mem_access_i(emu_mem),
    .cpu_bus_request_n_o(req_n), .cpu_grant_ack_n_o(gack_n), .target_bus_grant_n_o(tgnt_n),
    .dma_cycle_n_o(dcyc_n), .memory_cycle_n_o(mcyc_n), .dma_active_async_o(dact),
    .host_dma_strobe_n_o(hstb_n), .analysis_only_qualifier_n_o(qual_n), .tag_pulse_o(tag_p),
    .memavail_suppress_o(supp), .memory_available_flag_o(avail),
    .target_drive_enable_n_o(den_n), .target_transfer_ack_n_o(xack_n),
    .target_transfer_ack_oe_o(xack_oe)
  );

  epba_target_model epba_target_model_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .hold_i(hold),
    .cpu_bus_request_n_i(req_n), .target_bus_grant_n_i(tgnt_n),
    .target_bus_request_n_o(treq_n), .target_grant_ack_n_o(tack_n),
    .cpu_bus_grant_n_o(cgnt_n), .done_o(mdone)
  );

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_word(name, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge clk_i);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= ad;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic go_target(input logic [3:0] h);
    @(posedge clk_i);
    hold <= h;
    go   <= 1'b1;
    @(posedge clk_i);
    go   <= 1'b0;
  endtask

  task automatic ts_lat(input logic r, output int cnt);
    @(posedge clk_i);
    if (r) begin
      cpu_rst_n <= 1'b0;
    end else begin
      halt_n <= 1'b0;
    end
    cnt = 0;
    while (den_n !== 1'b1 && cnt < 30) begin
      @(negedge clk_i);
      cnt++;
    end
    @(posedge clk_i);
    halt_n    <= 1'b1;
    cpu_rst_n <= 1'b1;
    repeat (12) @(negedge clk_i);
    chk_bit("drive enable after halt", 1'b0, den_n);
  endtask

  task automatic wrap_up;
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_regs;
    ahb(1'b1, 32'h0, 32'h1f);
    ahb(1'b0, 32'h0, 32'h0);
    chk_word("ctrl readback", 32'h1f, rd);
    chk_bit("okay response", 1'b0, hresp);
    @(negedge clk_i);
    chk_bit("suppress", 1'b1, supp);
    chk_bit("qualifier monitor", 1'b0, qual_n);
    ahb(1'b1, 32'h0, 32'h2);
    @(negedge clk_i);
    chk_bit("suppress ignore", 1'b1, supp);
    chk_bit("qualifier idle", 1'b1, qual_n);
    chk_bit("available ignore", 1'b0, avail);
    ahb(1'b1, 32'h100, 32'hffffffff);
    ahb(1'b0, 32'h100, 32'h0);
    chk_word("unmapped read", 32'h0, rd);
    ahb(1'b1, 32'h4, 32'hffffffff);
    ahb(1'b0, 32'h4, 32'h0);
    chk_word("status state idle", 32'h0, {29'h0, rd[2:0]});
    $display("test regs done");
  endtask

  task automatic t_target;
    emu_mem <= 1'b1;
    ahb(1'b1, 32'h0, 32'h10);
    go_target(4'hc);
    for (n = 0; n < 20 && req_n !== 1'b0; n++) @(negedge clk_i);
    chk_bit("cpu bus request", 1'b0, req_n);
    for (n = 0; n < 20 && tgnt_n !== 1'b0; n++) @(negedge clk_i);
    chk_bit("target grant", 1'b0, tgnt_n);
    chk_bit("processor grant with target grant", 1'b0, cgnt_n);
    chk_bit("dma active early", 1'b1, dact);
    for (n = 0; n < 20 && dcyc_n !== 1'b0; n++) @(negedge clk_i);
    chk_bit("dma cycle", 1'b0, dcyc_n);
    chk_bit("grant ack out", 1'b0, gack_n);
    @(posedge clk_i);
    as_n <= 1'b0;
    a = 0;
    b = 0;
    repeat (8) begin
      @(negedge clk_i);
      a += (mcyc_n === 1'b0);
      b += (xack_oe === 1'b1);
    end
    chk_bit("memory cycle synced", 1'b1, a > 0);
    chk_word("transfer ack pulses", 32'h1, b);
    chk_bit("transfer ack level", 1'b0, xack_n);
    @(posedge clk_i);
    as_n <= 1'b1;
    for (n = 0; n < 40 && (mdone !== 1'b1 || req_n !== 1'b1); n++) @(negedge clk_i);
    chk_bit("request withdrawn", 1'b1, req_n);
    emu_mem <= 1'b0;
    $display("test target done");
  endtask

  task automatic t_tag;
    ahb(1'b1, 32'h0, 32'h4);
    go_target(4'h5);
    a = 0;
    b = 0;
    repeat (60) begin
      @(negedge clk_i);
      a += (tag_p === 1'b1);
      b += (qual_n === 1'b0);
    end
    chk_word("tag pulses", 32'h1, a);
    chk_word("qualifier clocks", 32'h2, b);
    chk_bit("suppress tag", 1'b1, supp);
    $display("test tag done");
  endtask

  task automatic t_host;
    ahb(1'b1, 32'h0, 32'h0);
    @(negedge clk_i);
    chk_bit("memory available", 1'b1, avail);
    @(posedge clk_i);
    host_n <= 1'b0;
    for (n = 0; n < 30 && hstb_n !== 1'b0; n++) @(negedge clk_i);
    chk_bit("host strobe", 1'b0, hstb_n);
    chk_bit("host request", 1'b0, req_n);
    @(posedge clk_i);
    dma_rst_n <= 1'b0;
    for (n = 0; n < 8 && req_n !== 1'b1; n++) @(negedge clk_i);
    chk_bit("request after dma reset", 1'b1, req_n);
    chk_bit("no grant after dma reset", 1'b1, tgnt_n);
    @(posedge clk_i);
    host_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    dma_rst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    start_n <= 1'b0;
    ahb(1'b0, 32'h4, 32'h0);
    chk_word("pending after start", 32'h0, {27'h0, rd[4:3], 3'h0});
    start_n <= 1'b1;
    $display("test host done");
  endtask

  task automatic t_tristate;
    ts_lat(1'b0, l0);
    chk_bit("undelayed tristate", 1'b1, l0 < 30);
    ahb(1'b1, 32'h0, 32'h1);
    ts_lat(1'b0, l1);
    chk_word("delayed tristate", l0 + 4, l1);
    ts_lat(1'b1, a);
    chk_word("delayed tristate reset", l0 + 4, a);
    $display("test tristate done");
  endtask

  // ----------------------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    sys_rst_i = 1'b1;
    {hsel, hwrite, go, emu_mem} = 4'h0;
    {host_n, dma_rst_n, as_n, halt_n, start_n, cpu_rst_n} = 6'h3f;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hold = 4'h0;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit("reset request", 1'b1, req_n);
    chk_bit("reset grant", 1'b1, tgnt_n);
    chk_bit("reset qualifier", 1'b1, qual_n);
    chk_bit("reset drive enable", 1'b0, den_n);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_target();
    t_tag();
    t_host();
    t_tristate();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
